// ==== verilog/rx_irq_pkg.sv ====
`default_nettype none
package rx_irq_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_FLAGS  = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MASK   = 8'h0C;
  localparam logic [7:0] ADDR_CTRL   = 8'h10;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_WAKE  = 7;
  localparam int BIT_CSC   = 6;
  localparam int BIT_OVR   = 1;
  localparam int BIT_RXF   = 0;
  localparam int RSENS_LSB = 4;
  localparam int TSENS_LSB = 2;

  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] SENS_MASK    = 8'h3C;

  // ****************************************
  // State coding and thresholds
  // ****************************************
  localparam logic [1:0] ST_OK      = 2'h0;
  localparam logic [1:0] ST_WARN    = 2'h1;
  localparam logic [1:0] ST_ERR     = 2'h2;
  localparam logic [1:0] ST_BUSOFF  = 2'h3;
  localparam logic [8:0] LIM_WARN   = 9'h060;
  localparam logic [8:0] LIM_ERR    = 9'h07F;
  localparam logic [8:0] LIM_BUSOFF = 9'h0FF;

  localparam logic [1:0] SENS_NONE   = 2'h0;
  localparam logic [1:0] SENS_BUSOFF = 2'h1;
  localparam logic [1:0] SENS_ERR    = 2'h2;

endpackage
`default_nettype wire

// ==== verilog/state_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
module state_filter
(
  input  wire logic [1:0] old_state_i,
  input  wire logic [1:0] new_state_i,
  input  wire logic [1:0] sensitivity_i,
  output logic            hit_o
);

  logic old_hi;
  logic new_hi;

  // ****************************************
  // Sensitivity classes
  // ****************************************
  always_comb
  begin
    old_hi = 1'b0;
    new_hi = 1'b0;
    hit_o  = 1'b0;
    case (sensitivity_i)
      rx_irq_pkg::SENS_NONE:
      begin
        hit_o = 1'b0;
      end
      rx_irq_pkg::SENS_BUSOFF:
      begin
        old_hi = (old_state_i == rx_irq_pkg::ST_BUSOFF);
        new_hi = (new_state_i == rx_irq_pkg::ST_BUSOFF);
        hit_o  = old_hi != new_hi;
      end
      rx_irq_pkg::SENS_ERR:
      begin
        old_hi = old_state_i[1];
        new_hi = new_state_i[1];
        hit_o  = (old_hi != new_hi) || (old_state_i[1] && new_state_i[1] && old_state_i != new_state_i);
      end
      default:
      begin
        hit_o = old_state_i != new_state_i;
      end
    endcase
  end

endmodule
`default_nettype wire

// ==== verilog/can_rx_interrupt_enable.sv ====
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module can_rx_interrupt_enable
(
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic [7:0]  rx_err_count_i,
  input  wire logic [8:0]  tx_err_count_i,
  input  wire logic        bus_activity_i,
  input  wire logic        sleep_mode_i,
  input  wire logic        overrun_i,
  input  wire logic        rx_msg_done_i,
  output logic             wake_irq_o,
  output logic             err_irq_o,
  output logic             rx_irq_o,
  output logic             irq_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0]  enable;
    logic [7:0]  ctrl;
    logic        wake_flag;
    logic        status_change_flag;
    logic        overrun_flag;
    logic        rx_full_flag;
    logic [1:0]  rx_bus_state;
    logic [1:0]  tx_bus_state;
    logic [3:0]  sticky;
    logic [3:0]  mask;
    logic        ph_write;
    logic [7:0]  ph_addr;
    logic [31:0] rdata;
    logic        wake_irq;
    logic        err_irq;
    logic        rx_irq;
    logic        irq;
  } state_t;

  state_t st_q;
  state_t st_d;

  logic       init_request;
  logic       init_acknowledge;
  logic       init_mode;
  logic       init_any;
  logic       wake_function_enable;
  logic [1:0] rx_state_sensitivity;
  logic [1:0] tx_state_sensitivity;
  logic [1:0] rx_now;
  logic [1:0] tx_now;
  logic       rx_hit;
  logic       tx_hit;
  logic       addr_phase;
  logic [7:0] flags_view;
  logic [3:0] events;

  assign init_request         = st_q.ctrl[0];
  assign init_acknowledge     = st_q.ctrl[0];
  assign init_mode            = init_request && init_acknowledge;
  assign init_any             = init_request || init_acknowledge;
  assign wake_function_enable = st_q.ctrl[2];
  assign rx_state_sensitivity = st_q.enable[rx_irq_pkg::RSENS_LSB +: 2];
  assign tx_state_sensitivity = st_q.enable[rx_irq_pkg::TSENS_LSB +: 2];
  assign addr_phase           = hsel_i && htrans_i[1] && hready_i;

  // ****************************************
  // Error counter to state
  // ****************************************
  always_comb
  begin
    tx_now = rx_irq_pkg::ST_OK;
    rx_now = rx_irq_pkg::ST_OK;
    // Transmitter thresholds, highest first
    if (tx_err_count_i > rx_irq_pkg::LIM_BUSOFF)
    begin
      tx_now = rx_irq_pkg::ST_BUSOFF;
    end
    else if (tx_err_count_i > rx_irq_pkg::LIM_ERR)
    begin
      tx_now = rx_irq_pkg::ST_ERR;
    end
    else if (tx_err_count_i > rx_irq_pkg::LIM_WARN)
    begin
      tx_now = rx_irq_pkg::ST_WARN;
    end
    // Receiver follows transmitter into bus-off
    if (tx_now == rx_irq_pkg::ST_BUSOFF)
    begin
      rx_now = rx_irq_pkg::ST_BUSOFF;
    end
    else if ({1'b0, rx_err_count_i} > rx_irq_pkg::LIM_ERR)
    begin
      rx_now = rx_irq_pkg::ST_ERR;
    end
    else if ({1'b0, rx_err_count_i} > rx_irq_pkg::LIM_WARN)
    begin
      rx_now = rx_irq_pkg::ST_WARN;
    end
  end

  state_filter u_rx_filter
  (
    .old_state_i   (st_q.rx_bus_state),
    .new_state_i   (rx_now),
    .sensitivity_i (rx_state_sensitivity),
    .hit_o         (rx_hit)
  );

  state_filter u_tx_filter
  (
    .old_state_i   (st_q.tx_bus_state),
    .new_state_i   (tx_now),
    .sensitivity_i (tx_state_sensitivity),
    .hit_o         (tx_hit)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    st_d = st_q;
    events = 4'h0;

    // Bus status tracking, blocked while flag pending
    if (!st_q.status_change_flag)
    begin
      st_d.rx_bus_state = rx_now;
      st_d.tx_bus_state = tx_now;
      if (rx_hit || tx_hit)
        events[2] = 1'b1;
    end
    if (bus_activity_i && sleep_mode_i && wake_function_enable)
      events[3] = 1'b1;
    events[1] = overrun_i;
    events[0] = rx_msg_done_i;

    // Bus data phase: software clears with one, set wins
    if (st_q.ph_write)
    begin
      case (st_q.ph_addr)
        rx_irq_pkg::ADDR_ENABLE:
        begin
          if (!init_any)
            st_d.enable = hwdata_i[7:0];
        end
        rx_irq_pkg::ADDR_FLAGS:
        begin
          if (!init_any)
          begin
            if (hwdata_i[rx_irq_pkg::BIT_WAKE])
              st_d.wake_flag = 1'b0;
            if (hwdata_i[rx_irq_pkg::BIT_CSC])
              st_d.status_change_flag = 1'b0;
            if (hwdata_i[rx_irq_pkg::BIT_OVR])
              st_d.overrun_flag = 1'b0;
            if (hwdata_i[rx_irq_pkg::BIT_RXF])
              st_d.rx_full_flag = 1'b0;
          end
        end
        rx_irq_pkg::ADDR_STATUS:
        begin
          st_d.sticky = st_q.sticky & ~hwdata_i[3:0];
        end
        rx_irq_pkg::ADDR_MASK:
        begin
          st_d.mask = hwdata_i[3:0];
        end
        rx_irq_pkg::ADDR_CTRL:
        begin
          st_d.ctrl = hwdata_i[7:0];
        end
        default:
        begin
          st_d.ctrl = st_q.ctrl;
        end
      endcase
    end

    // Events applied last, so a set beats a clear
    if (events[3])
    begin
      st_d.wake_flag = 1'b1;
    end
    if (events[2])
    begin
      st_d.status_change_flag = 1'b1;
    end
    if (events[1])
    begin
      st_d.overrun_flag = 1'b1;
    end
    if (events[0])
    begin
      st_d.rx_full_flag = 1'b1;
    end
    st_d.sticky = st_d.sticky | events;

    // Init mode returns enables to reset value, keeps sensitivities
    if (init_mode)
      st_d.enable = (rx_irq_pkg::ENABLE_RESET & ~rx_irq_pkg::SENS_MASK) | (st_d.enable & rx_irq_pkg::SENS_MASK);

    // Requests
    st_d.wake_irq = st_q.wake_flag && st_q.enable[rx_irq_pkg::BIT_WAKE];
    st_d.err_irq  = (st_q.status_change_flag && st_q.enable[rx_irq_pkg::BIT_CSC])
                  || (st_q.overrun_flag && st_q.enable[rx_irq_pkg::BIT_OVR]);
    st_d.rx_irq   = st_q.rx_full_flag && st_q.enable[rx_irq_pkg::BIT_RXF];
    st_d.irq      = |(st_q.sticky & st_q.mask);

    // Address phase and read data
    st_d.ph_write = addr_phase && hwrite_i;
    st_d.ph_addr  = haddr_i[7:0];
    if (addr_phase && !hwrite_i)
    begin
      case (haddr_i[7:0])
        rx_irq_pkg::ADDR_ENABLE:
        begin
          st_d.rdata = {24'h00_0000, st_q.enable};
        end
        rx_irq_pkg::ADDR_FLAGS:
        begin
          st_d.rdata = {24'h00_0000, flags_view};
        end
        rx_irq_pkg::ADDR_STATUS:
        begin
          st_d.rdata = {28'h000_0000, st_q.sticky};
        end
        rx_irq_pkg::ADDR_MASK:
        begin
          st_d.rdata = {28'h000_0000, st_q.mask};
        end
        rx_irq_pkg::ADDR_CTRL:
        begin
          st_d.rdata = {24'h00_0000, st_q.ctrl};
        end
        default:
        begin
          st_d.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  assign flags_view = {st_q.wake_flag, st_q.status_change_flag, st_q.rx_bus_state,
                       st_q.tx_bus_state, st_q.overrun_flag, st_q.rx_full_flag};

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      st_q        <= '0;
      st_q.enable <= rx_irq_pkg::ENABLE_RESET;
    end
    else
      st_q <= st_d;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // Outputs straight from flops, quiet in reset
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      hrdata_o   <= 32'h0000_0000;
      wake_irq_o <= 1'b0;
      err_irq_o  <= 1'b0;
      rx_irq_o   <= 1'b0;
      irq_o      <= 1'b0;
    end
    else
    begin
      hrdata_o   <= st_d.rdata;
      wake_irq_o <= st_d.wake_irq;
      err_irq_o  <= st_d.err_irq;
      rx_irq_o   <= st_d.rx_irq;
      irq_o      <= st_d.irq;
    end
  end

endmodule
`default_nettype wire

// ==== testbench/rx_irq_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module rx_irq_monitor
(
  input wire logic        clk_sys_i,
  input wire logic        resetn_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        overrun_i,
  input wire logic        rx_msg_done_i,
  input wire logic        wake_irq_o,
  input wire logic        err_irq_o,
  input wire logic        rx_irq_o
);
  // ****************************************
  // Shadow of enable and init from bus writes
  // ****************************************
  logic       wr_q;
  logic [7:0] adr_q;
  logic [7:0] en_q;
  logic       init_q;
  wire logic  err_en = en_q[6] | en_q[1];
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      wr_q   <= 1'b0;
      adr_q  <= 8'h00;
      en_q   <= 8'h00;
      init_q <= 1'b0;
    end
    else
    begin
      wr_q  <= hsel_i & htrans_i[1] & hready_i & hwrite_i;
      adr_q <= haddr_i[7:0];
      if (wr_q && adr_q == rx_irq_pkg::ADDR_CTRL) init_q <= hwdata_i[0];
      if (init_q) en_q <= en_q & rx_irq_pkg::SENS_MASK;
      else if (wr_q && adr_q == rx_irq_pkg::ADDR_ENABLE) en_q <= hwdata_i[7:0];
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  sequence rx_ev_s;
    rx_msg_done_i && en_q[0] ##1 en_q[0];
  endsequence
  sequence ovr_ev_s;
    overrun_i && en_q[1] ##1 en_q[1];
  endsequence
  AST_READY: assert property ($past(resetn_i) |-> hreadyout_o)
    else $error("ready low out of reset");
  AST_OKAY: assert property (!hresp_o)
    else $error("response not okay");
  AST_RXF_GATE: assert property (rx_irq_o |-> $past(en_q[0]) || $past(en_q[0], 2))
    else $error("rx request while disabled");
  AST_WAKE_GATE: assert property (wake_irq_o |-> $past(en_q[7]) || $past(en_q[7], 2))
    else $error("wake request while disabled");
  AST_ERR_GATE: assert property (err_irq_o |-> $past(err_en) || $past(err_en, 2))
    else $error("error request while disabled");
  AST_INIT_HOLD: assert property ($past(init_q) && $past(init_q, 2) |-> !(rx_irq_o | wake_irq_o | err_irq_o))
    else $error("request during init");
  AST_RX_EVENT: assert property (rx_ev_s |-> ##1 rx_irq_o)
    else $error("rx request missing");
  AST_OVR_EVENT: assert property (ovr_ev_s |-> ##1 err_irq_o)
    else $error("overrun request missing");
endmodule
bind can_rx_interrupt_enable rx_irq_monitor u_mon (.clk_sys_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i,
  .hwrite_i, .hwdata_i, .hready_i, .hreadyout_o, .hresp_o, .overrun_i, .rx_msg_done_i, .wake_irq_o,
  .err_irq_o, .rx_irq_o);
`default_nettype wire

// ==== testbench/can_node_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module can_node_model
(
  input  wire logic       clk_i,
  output logic      [7:0] rx_cnt_o,
  output logic      [8:0] tx_cnt_o,
  output logic            act_o,
  output logic            sleep_o,
  output logic            ovr_o,
  output logic            done_o
);
  // ****************************************
  // Bus side counters and one cycle events
  // ****************************************
  initial {rx_cnt_o, tx_cnt_o, act_o, sleep_o, ovr_o, done_o} = '0;
  task automatic set_cnt(input int r, input int t);
    @(posedge clk_i);
    rx_cnt_o <= r[7:0];
    tx_cnt_o <= t[8:0];
  endtask
  task automatic fire(input int e);
    @(posedge clk_i);
    done_o  <= (e == 0);
    ovr_o   <= (e == 1);
    act_o   <= (e == 2);
    sleep_o <= (e == 2);
    @(posedge clk_i);
    {act_o, sleep_o, ovr_o, done_o} <= '0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_sys_i = 0;
  logic        resetn_i  = 0;
  logic        hsel      = 0;
  logic        hwrite    = 0;
  logic [1:0]  htrans    = 0;
  logic [31:0] haddr     = 0;
  logic [31:0] hwdata    = 0;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic        hready, hresp, wake_irq, err_irq, rx_irq, irq, act, slp, ovr, done;
  logic [7:0]  rxc;
  logic [8:0]  txc;
  int          err_total = 0;
  int          tests_run = 0;
  int          s, k, e, en, r, t, rn, tn, h;
  always #2 clk_sys_i = ~clk_sys_i;
  can_node_model u_node (.clk_i(clk_sys_i), .rx_cnt_o(rxc), .tx_cnt_o(txc), .act_o(act), .sleep_o(slp),
    .ovr_o(ovr), .done_o(done));
  can_rx_interrupt_enable u_dut (.clk_sys_i, .resetn_i, .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .rx_err_count_i(rxc), .tx_err_count_i(txc), .bus_activity_i(act),
    .sleep_mode_i(slp), .overrun_i(ovr), .rx_msg_done_i(done), .wake_irq_o(wake_irq), .err_irq_o(err_irq),
    .rx_irq_o(rx_irq), .irq_o(irq));
  // ****************************************
  // Bus cycles, checks and model
  // ****************************************
  task automatic final_report;
    $display("tests %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x)
    begin
      err_total++;
      $display("Error at %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic step;
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1)
    begin
      err_total++;
      final_report();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    step();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    step();
    q = hrdata;
  endtask
  // Register reads only, never receive buffers
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, x);
  endtask
  function automatic int st(input int c);
    return c > 255 ? 3 : c > 127 ? 2 : c > 96 ? 1 : 0;
  endfunction
  function automatic int hit(input int o, input int n, input int sv);
    if (o == n || sv == 0) return 0;
    if (sv == 3) return 1;
    if (sv == 2) return int'(o >= 2 || n >= 2);
    return int'(o == 3 || n == 3);
  endfunction
  initial
  begin
    void'($urandom(65));
    w(4);
    resetn_i <= 1'b1;
    rd(rx_irq_pkg::ADDR_ENABLE, 0);
    rd(8'h20, 0);
    $display("test 1 done");
    bus(1'b1, rx_irq_pkg::ADDR_ENABLE, 8'hFF);
    rd(rx_irq_pkg::ADDR_ENABLE, 8'hFF);
    u_node.fire(0);
    w(3);
    chk({31'h0, rx_irq}, 1);
    bus(1'b1, rx_irq_pkg::ADDR_CTRL, 1);
    w(3);
    chk({31'h0, rx_irq}, 0);
    rd(rx_irq_pkg::ADDR_ENABLE, 8'h3C);
    bus(1'b1, rx_irq_pkg::ADDR_ENABLE, 0);
    rd(rx_irq_pkg::ADDR_ENABLE, 8'h3C);
    bus(1'b1, rx_irq_pkg::ADDR_CTRL, 4);
    rd(rx_irq_pkg::ADDR_ENABLE, 8'h3C);
    $display("test 2 done");
    for (e = 0; e < 3; e++)
      for (en = 0; en < 2; en++)
      begin
        bus(1'b1, rx_irq_pkg::ADDR_FLAGS, 8'hFF);
        bus(1'b1, rx_irq_pkg::ADDR_STATUS, 8'h0F);
        bus(1'b1, rx_irq_pkg::ADDR_ENABLE, en ? (e == 2 ? 128 : 1 << e) : 0);
        bus(1'b1, rx_irq_pkg::ADDR_MASK, en ? 15 : 0);
        u_node.fire(e);
        w(3);
        chk({31'h0, e == 0 ? rx_irq : e == 1 ? err_irq : wake_irq}, en);
        chk({31'h0, irq}, en);
        rd(rx_irq_pkg::ADDR_STATUS, 1 << (e == 2 ? 3 : e));
      end
    bus(1'b1, rx_irq_pkg::ADDR_FLAGS, 8'hFF);
    $display("test 3 done");
    for (s = 0; s < 4; s++)
      for (k = 0; k < 5; k++)
      begin
        bus(1'b1, rx_irq_pkg::ADDR_ENABLE, 64 | s << 4 | s << 2);
        r  = k == 0 ? 97 + $urandom % 31 : k == 1 ? 128 + $urandom % 128 : 0;
        t  = k == 2 ? 97 + $urandom % 31 : k == 3 ? 128 + $urandom % 128 : k == 4 ? 256 + $urandom % 256 : 0;
        tn = st(t);
        rn = tn == 3 ? 3 : st(r);
        h  = hit(0, rn, s) | hit(0, tn, s);
        u_node.set_cnt(r, t);
        w(4);
        rd(rx_irq_pkg::ADDR_FLAGS, h << 6 | rn << 4 | tn << 2);
        chk({31'h0, err_irq}, h);
        u_node.set_cnt(0, 0);
        w(4);
        rd(rx_irq_pkg::ADDR_FLAGS, h ? (64 | rn << 4 | tn << 2) : 0);
        bus(1'b1, rx_irq_pkg::ADDR_FLAGS, 64);
        w(4);
        bus(1'b1, rx_irq_pkg::ADDR_FLAGS, 64);
        w(4);
      end
    $display("test 4 done");
    final_report();
  end
endmodule
`default_nettype wire
